// *** design/tlprq_hdr_mem.v ***
// Small word store that holds one request packet while it is sent.
// Assumes one writer and one reader on the same clock; read data is
// registered, so it appears one edge after the read address.
`include "tlprq_map.vh"

module tlprq_hdr_mem (
    // Clock
    input wire core_clk,
    // Write port
    input wire wrEn,
    input wire [`TLPRQ_MEM_AW-1:0] wrAddr,
    input wire [31:0] wrData,
    // Read port
    input wire [`TLPRQ_MEM_AW-1:0] rdAddr,
    output reg [31:0] rdData_q
);
    reg [31:0] words [0:`TLPRQ_MEM_DEPTH-1];

    always @(posedge core_clk) begin
        if (wrEn) begin
            words[wrAddr] <= wrData;
        end
        rdData_q <= words[rdAddr];
    end
endmodule

// *** design/tlprq_host_ctrl.v ***
// Request generator that drives a header-checking port from outside.
// Software sets up one request over Wishbone, then starts it; the block
// builds the packet and sends it word by word with valid and ready.
// Assumes the checking port answers ready and pulses its malformed flag.
//
// Contract
// - I/O requests: address routed, 32-bit address.
// - I/O: TC0, attr 0, length 1, last BE 0.
// - Config requests: ID routed, three-word header.
// - Config header carries register and extended numbers.
// - Config: TC0, attr 0, length 1, last BE 0.
// - Messages carry requester ID, tag, message code.
// - Msg type; data only vendor or slot power.
// - Message attr and bytes 8-15 reserved; address-routed messages carry addrHi_q and addrLo_q there.
// - Messages are posted, no completion awaited.
// - Gathered routing only for the turn-off acknowledge.
// - Eight interrupt messages, assert/deassert per line.
// - Interrupt messages: no payload, Msg, length reserved.
// - Only upstream ports send interrupt messages.
// - Interrupt messages use TC0, receiver checks.
// - Interrupt messages: local routing, codes 20h-27h.
`include "tlprq_map.vh"

module tlprq_host_ctrl #(
    // Message codes that vary by system; values are arbitrary defaults.
    parameter [7:0] PME_TO_ACK_CODE = 8'h01,
    parameter [7:0] SLOT_PWR_CODE = 8'h02,
    parameter [7:0] VENDOR_CODE_A = 8'h03,
    parameter [7:0] VENDOR_CODE_B = 8'h04
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Wishbone slave
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [7:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatW,
    output reg [31:0] wbDatR_q,
    output reg wbAck_q,
    // Packet stream toward the checking port
    output reg txValid_q,
    output reg txSop_q,
    output reg txEop_q,
    output reg [31:0] txData_q,
    input wire txReady,
    // Error pulse from the checking port
    input wire malformedPulse
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_LOAD = 3'h1;
    localparam [2:0] ST_FETCH = 3'h2;
    localparam [2:0] ST_SHOW = 3'h3;
    localparam [2:0] ST_WAIT = 3'h4;

    reg [31:0] ctrl_q;
    reg [31:0] id_q;
    reg [31:0] addrLo_q;
    reg [31:0] addrHi_q;
    reg [31:0] target_q;
    reg [31:0] msg_q;
    reg [31:0] data_q;
    reg refused_q;
    reg done_q;
    reg [7:0] errCnt_q;
    reg [2:0] state_q;
    reg [2:0] idx_q;
    reg [2:0] nWords_q;

    // Byte-lane merge used by every writable register.
    function [31:0] mergeBytes;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0] sel;
        input [31:0] mask;
        integer i;
        begin
            mergeBytes = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    mergeBytes[i*8 +: 8] = wdat[i*8 +: 8];
                end
            end
            mergeBytes = mergeBytes & mask;
        end
    endfunction

    // Builds the first header word from its variable fields.
    function [31:0] firstWord;
        input hasData;
        input fourDw;
        input [4:0] typ;
        input [2:0] tc;
        input [9:0] len;
        begin
            firstWord = {1'b0, hasData, fourDw, typ, 1'b0, tc, 4'h0,
                2'b00, `TLPRQ_ATTR_NONE, 2'b00, len};
        end
    endfunction

    wire busy = (state_q != ST_IDLE);
    wire wbReq = wbCyc & wbStb & ~wbAck_q;
    wire wbWr = wbReq & wbWe;
    wire [7:0] ofs = {wbAdr[7:2], 2'b00};
    wire [2:0] kind = ctrl_q[`TLPRQ_CTRL_KIND];
    wire [7:0] msgCode = msg_q[`TLPRQ_MSG_CODE];
    wire [2:0] route = msg_q[`TLPRQ_MSG_ROUTE];
    wire msgData = msg_q[`TLPRQ_MSG_DATA];
    wire [15:0] reqId = id_q[`TLPRQ_ID_REQ];
    wire [7:0] tag = id_q[`TLPRQ_ID_TAG];
    wire [3:0] firstBe = target_q[`TLPRQ_TGT_FBE];
    wire goWrite = wbWr && ofs == `TLPRQ_OFS_CTRL && wbSel[1] &&
        wbDatW[`TLPRQ_CTRL_GO];
    wire fieldWr = wbWr & ~busy;

    // Header words for the request now set up.
    reg [31:0] dw0;
    reg [31:0] dw1;
    reg [31:0] dw2;
    reg [31:0] dw3;
    reg hasData;
    reg fourDw;
    reg [7:0] intxCode;
    reg refuse;

    always @* begin
        hasData = 1'b0;
        fourDw = 1'b0;
        dw0 = 32'h0000_0000;
        dw1 = {reqId, tag, `TLPRQ_BE_NONE, firstBe};
        dw2 = {addrLo_q[31:2], 2'b00};
        dw3 = 32'h0000_0000;
        intxCode = (msg_q[`TLPRQ_MSG_DEASSERT] ? `TLPRQ_CODE_DEASSERT :
            `TLPRQ_CODE_ASSERT) + {6'h00, msg_q[`TLPRQ_MSG_LINE]};
        refuse = 1'b0;
        case (kind)
            `TLPRQ_KIND_IO: begin
                hasData = ctrl_q[`TLPRQ_CTRL_WRITE];
                dw0 = firstWord(hasData, 1'b0, `TLPRQ_TYPE_IO, `TLPRQ_TC0,
                    `TLPRQ_LEN_ONE);
            end
            `TLPRQ_KIND_CFG: begin
                hasData = ctrl_q[`TLPRQ_CTRL_WRITE];
                dw0 = firstWord(hasData, 1'b0, ctrl_q[`TLPRQ_CTRL_TYPE1] ?
                    `TLPRQ_TYPE_CFG1 : `TLPRQ_TYPE_CFG0, `TLPRQ_TC0,
                    `TLPRQ_LEN_ONE);
                dw2 = {target_q[`TLPRQ_TGT_BUS], target_q[`TLPRQ_TGT_DEV],
                    target_q[`TLPRQ_TGT_FUNC], 4'h0,
                    target_q[`TLPRQ_TGT_EXT], target_q[`TLPRQ_TGT_REG],
                    2'b00};
            end
            `TLPRQ_KIND_MSI: begin
                // A 64-bit form is used whenever the upper half is set.
                hasData = 1'b1;
                fourDw = (addrHi_q != 32'h0000_0000);
                dw0 = firstWord(1'b1, fourDw, `TLPRQ_TYPE_MWR,
                    `TLPRQ_TC0, `TLPRQ_LEN_ONE);
                dw2 = fourDw ? addrHi_q : {addrLo_q[31:2], 2'b00};
                dw3 = {addrLo_q[31:2], 2'b00};
            end
            `TLPRQ_KIND_MSG: begin
                hasData = msgData;
                fourDw = 1'b1;
                dw0 = firstWord(hasData, 1'b1, {`TLPRQ_TYPE_MSG_HI, route},
                    msg_q[`TLPRQ_MSG_TC], hasData ? `TLPRQ_LEN_ONE :
                    `TLPRQ_LEN_NONE);
                dw1 = {reqId, tag, msgCode};
                if (route == `TLPRQ_RT_ADDR) begin
                    dw2 = addrHi_q;
                    dw3 = {addrLo_q[31:2], 2'b00};
                end else begin
                    dw2 = 32'h0000_0000;
                end
                refuse = (route[2:1] == `TLPRQ_RT_RSV_HI) ||
                    (route == `TLPRQ_RT_GATHER &&
                    msgCode != PME_TO_ACK_CODE) ||
                    (msgCode[7:3] == `TLPRQ_CODE_INTX_HI) ||
                    (msgData && msgCode != VENDOR_CODE_A &&
                    msgCode != VENDOR_CODE_B &&
                    msgCode != SLOT_PWR_CODE) ||
                    (msgCode == SLOT_PWR_CODE && !msgData);
            end
            `TLPRQ_KIND_INTX: begin
                fourDw = 1'b1;
                dw0 = firstWord(1'b0, 1'b1,
                    {`TLPRQ_TYPE_MSG_HI, `TLPRQ_RT_LOCAL}, `TLPRQ_TC0,
                    `TLPRQ_LEN_NONE);
                dw1 = {reqId, tag, intxCode};
                dw2 = 32'h0000_0000;
                refuse = ~ctrl_q[`TLPRQ_CTRL_UPSTREAM];
            end
            default: begin
                refuse = 1'b1;
            end
        endcase
    end

    wire [2:0] nWords = (fourDw ? `TLPRQ_DW4 : `TLPRQ_DW3) +
        {2'b00, hasData};
    reg [31:0] loadWord;

    always @* begin
        case (idx_q)
            3'h0: loadWord = dw0;
            3'h1: loadWord = dw1;
            3'h2: loadWord = dw2;
            3'h3: loadWord = fourDw ? dw3 : data_q;
            default: loadWord = data_q;
        endcase
    end

    wire [31:0] rdData;

    tlprq_hdr_mem mem (
        .core_clk(core_clk),
        .wrEn(state_q == ST_LOAD),
        .wrAddr(idx_q),
        .wrData(loadWord),
        .rdAddr(idx_q),
        .rdData_q(rdData)
    );

    // Register file; field writes are ignored while a packet is in flight
    // so that the header cannot change under the sender.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= 32'h0000_0000;
            id_q <= 32'h0000_0000;
            addrLo_q <= 32'h0000_0000;
            addrHi_q <= 32'h0000_0000;
            target_q <= 32'h0000_0000;
            msg_q <= 32'h0000_0000;
            data_q <= 32'h0000_0000;
            wbAck_q <= 1'b0;
            wbDatR_q <= 32'h0000_0000;
        end else begin
            wbAck_q <= wbReq;
            wbDatR_q <= 32'h0000_0000;
            if (wbReq && !wbWe) begin
                case (ofs)
                    `TLPRQ_OFS_CTRL: wbDatR_q <= ctrl_q;
                    `TLPRQ_OFS_ID: wbDatR_q <= id_q;
                    `TLPRQ_OFS_ADDRLO: wbDatR_q <= addrLo_q;
                    `TLPRQ_OFS_ADDRHI: wbDatR_q <= addrHi_q;
                    `TLPRQ_OFS_TARGET: wbDatR_q <= target_q;
                    `TLPRQ_OFS_MSG: wbDatR_q <= msg_q;
                    `TLPRQ_OFS_DATA: wbDatR_q <= data_q;
                    `TLPRQ_OFS_STATUS: begin
                        wbDatR_q[`TLPRQ_ST_BUSY] <= busy;
                        wbDatR_q[`TLPRQ_ST_REFUSED] <= refused_q;
                        wbDatR_q[`TLPRQ_ST_DONE] <= done_q;
                        wbDatR_q[`TLPRQ_ST_ERRCNT] <= errCnt_q;
                    end
                    default: wbDatR_q <= 32'h0000_0000;
                endcase
            end
            if (fieldWr) begin
                case (ofs)
                    `TLPRQ_OFS_CTRL: ctrl_q <= mergeBytes(ctrl_q, wbDatW,
                        wbSel, `TLPRQ_CTRL_MASK);
                    `TLPRQ_OFS_ID: id_q <= mergeBytes(id_q, wbDatW, wbSel,
                        `TLPRQ_ID_MASK);
                    `TLPRQ_OFS_ADDRLO: addrLo_q <= mergeBytes(addrLo_q,
                        wbDatW, wbSel, 32'hFFFF_FFFC);
                    `TLPRQ_OFS_ADDRHI: addrHi_q <= mergeBytes(addrHi_q,
                        wbDatW, wbSel, 32'hFFFF_FFFF);
                    `TLPRQ_OFS_TARGET: target_q <= mergeBytes(target_q,
                        wbDatW, wbSel, `TLPRQ_TGT_MASK);
                    `TLPRQ_OFS_MSG: msg_q <= mergeBytes(msg_q, wbDatW,
                        wbSel, `TLPRQ_MSG_MASK);
                    `TLPRQ_OFS_DATA: data_q <= mergeBytes(data_q, wbDatW,
                        wbSel, 32'hFFFF_FFFF);
                    default: ;
                endcase
            end
        end
    end

    // Status flags: a hardware set in the same cycle as a clear wins.
    wire stClr = wbWr && ofs == `TLPRQ_OFS_STATUS && wbSel[0];
    wire goTake = goWrite & ~busy;
    wire goRefuse = goWrite & (busy | refuse);
    wire sentLast = (state_q == ST_WAIT) & txReady & txEop_q;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            refused_q <= 1'b0;
            done_q <= 1'b0;
            errCnt_q <= 8'h00;
        end else begin
            refused_q <= goRefuse |
                (refused_q & ~(stClr & wbDatW[`TLPRQ_ST_REFUSED]));
            done_q <= sentLast |
                (done_q & ~(stClr & wbDatW[`TLPRQ_ST_DONE]));
            if (malformedPulse) begin
                errCnt_q <= errCnt_q + `TLPRQ_ERR_STEP;
            end
        end
    end

    // Sender: load the store, then send each word with valid and ready.
    // Messages end at the last word; nothing waits for a completion.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            idx_q <= 3'h0;
            nWords_q <= 3'h0;
            txValid_q <= 1'b0;
            txSop_q <= 1'b0;
            txEop_q <= 1'b0;
            txData_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    idx_q <= 3'h0;
                    if (goTake && !refuse) begin
                        nWords_q <= nWords;
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (idx_q == nWords_q - `TLPRQ_DW_1) begin
                        idx_q <= 3'h0;
                        state_q <= ST_FETCH;
                    end else begin
                        idx_q <= idx_q + `TLPRQ_DW_1;
                    end
                end
                ST_FETCH: begin
                    state_q <= ST_SHOW;
                end
                ST_SHOW: begin
                    txData_q <= rdData;
                    txValid_q <= 1'b1;
                    txSop_q <= (idx_q == 3'h0);
                    txEop_q <= (idx_q == nWords_q - `TLPRQ_DW_1);
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (txReady) begin
                        txValid_q <= 1'b0;
                        txSop_q <= 1'b0;
                        txEop_q <= 1'b0;
                        if (txEop_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            idx_q <= idx_q + `TLPRQ_DW_1;
                            state_q <= ST_FETCH;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** inc/tlprq_map.vh ***
// Constants for the request header generator: register map, header field
// codes and the little header store. Included by every design file.
// Assumes a 32-bit classic Wishbone slave port with byte addressing.
`ifndef TLPRQ_MAP_VH
`define TLPRQ_MAP_VH

// Register byte offsets.
`define TLPRQ_OFS_CTRL 8'h00
`define TLPRQ_OFS_ID 8'h04
`define TLPRQ_OFS_ADDRLO 8'h08
`define TLPRQ_OFS_ADDRHI 8'h0C
`define TLPRQ_OFS_TARGET 8'h10
`define TLPRQ_OFS_MSG 8'h14
`define TLPRQ_OFS_DATA 8'h18
`define TLPRQ_OFS_STATUS 8'h1C

// Control register fields.
`define TLPRQ_CTRL_KIND 2:0
`define TLPRQ_CTRL_UPSTREAM 3
`define TLPRQ_CTRL_WRITE 4
`define TLPRQ_CTRL_TYPE1 5
`define TLPRQ_CTRL_GO 8
`define TLPRQ_CTRL_MASK 32'h0000_003F

// Request kinds.
`define TLPRQ_KIND_IO 3'h0
`define TLPRQ_KIND_CFG 3'h1
`define TLPRQ_KIND_MSG 3'h2
`define TLPRQ_KIND_INTX 3'h3
`define TLPRQ_KIND_MSI 3'h4

// Identifier register fields.
`define TLPRQ_ID_REQ 15:0
`define TLPRQ_ID_TAG 23:16
`define TLPRQ_ID_MASK 32'h00FF_FFFF

// Target register fields.
`define TLPRQ_TGT_BUS 7:0
`define TLPRQ_TGT_DEV 12:8
`define TLPRQ_TGT_FUNC 15:13
`define TLPRQ_TGT_REG 21:16
`define TLPRQ_TGT_EXT 25:22
`define TLPRQ_TGT_FBE 29:26
`define TLPRQ_TGT_MASK 32'h3FFF_FFFF

// Message register fields.
`define TLPRQ_MSG_CODE 7:0
`define TLPRQ_MSG_ROUTE 10:8
`define TLPRQ_MSG_DATA 11
`define TLPRQ_MSG_LINE 13:12
`define TLPRQ_MSG_DEASSERT 14
`define TLPRQ_MSG_TC 17:15
`define TLPRQ_MSG_MASK 32'h0003_FFFF

// Status register fields.
`define TLPRQ_ST_BUSY 0
`define TLPRQ_ST_REFUSED 1
`define TLPRQ_ST_DONE 2
`define TLPRQ_ST_ERRCNT 15:8

// Header field codes.
`define TLPRQ_TYPE_IO 5'h02
`define TLPRQ_TYPE_CFG0 5'h04
`define TLPRQ_TYPE_CFG1 5'h05
`define TLPRQ_TYPE_MWR 5'h00
`define TLPRQ_TYPE_MSG_HI 2'h2
`define TLPRQ_TC0 3'h0
`define TLPRQ_ATTR_NONE 2'h0
`define TLPRQ_LEN_ONE 10'h001
`define TLPRQ_LEN_NONE 10'h000
`define TLPRQ_BE_NONE 4'h0
`define TLPRQ_BE_ALL 4'hF

// Message routing codes.
`define TLPRQ_RT_TO_ROOT 3'h0
`define TLPRQ_RT_ADDR 3'h1
`define TLPRQ_RT_ID 3'h2
`define TLPRQ_RT_BCAST 3'h3
`define TLPRQ_RT_LOCAL 3'h4
`define TLPRQ_RT_GATHER 3'h5
`define TLPRQ_RT_RSV_HI 2'h3

// Virtual-wire interrupt message codes.
`define TLPRQ_CODE_ASSERT 8'h20
`define TLPRQ_CODE_DEASSERT 8'h24
`define TLPRQ_CODE_INTX_HI 5'h04

// Header store and error count step.
`define TLPRQ_MEM_AW 3
`define TLPRQ_MEM_DEPTH 8
`define TLPRQ_DW3 3'h3
`define TLPRQ_DW4 3'h4
`define TLPRQ_DW_1 3'h1
`define TLPRQ_ERR_STEP 8'h01

`endif

// *** tb/test_tlprq_host_ctrl.sv ***
// Self-checking bench for the request generator and a checking port model.
// Assumes the Wishbone register map and packet layout of the shared header.
`include "tlprq_map.vh"
module test_tlprq_host_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, sys_rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0;
    logic injectBad = 0, t1, w, cfg, dm;
    logic [7:0] wbAdr = 0, code;
    logic [3:0] wbSel = 4'hF;
    logic [2:0] tc, rt;
    logic [31:0] wbDatW = 0, id, lo, hi = 0, dat, tgt, r;
    logic [31:0] exp[$];
    logic [63:0] refuse [7] = '{64'h0000_0003_0000_0000,
        64'h0000_0002_0000_0610, 64'h0000_0002_0000_0710,
        64'h0000_0002_0000_0510, 64'h0000_0002_0000_0422,
        64'h0000_0002_0000_0810, 64'h0000_0002_0000_0402};
    wire [31:0] wbDatR_q, txData_q;
    wire wbAck_q, txValid_q, txSop_q, txEop_q, txReady, malformedPulse;
    int num_errors = 0, n_checks = 0, expErr = 0;
    always #50 core_clk = ~core_clk;
    tlprq_host_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR_q(wbDatR_q),
        .wbAck_q(wbAck_q), .txValid_q(txValid_q), .txSop_q(txSop_q),
        .txEop_q(txEop_q), .txData_q(txData_q), .txReady(txReady),
        .malformedPulse(malformedPulse));
    tlprq_peer PEER (.core_clk(core_clk), .sys_rst(sys_rst),
        .txValid_q(txValid_q), .txSop_q(txSop_q), .txEop_q(txEop_q),
        .txData_q(txData_q), .txReady(txReady),
        .malformedPulse(malformedPulse), .injectBad(injectBad));
    task automatic end_of_test;
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", what, e, s);
            num_errors++;
        end
    endtask
    // Waits for the answer however long it takes; the watchdog ends a hang.
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        wbCyc <= 1;
        wbStb <= 1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        do begin
            @(posedge core_clk);
        end while (wbAck_q !== 1'b1);
        r = wbDatR_q;
        wbCyc <= 0;
        wbStb <= 0;
    endtask
    task automatic rnd;
        id = $urandom & `TLPRQ_ID_MASK;
        lo = $urandom & 32'hFFFF_FFFC;
        dat = $urandom;
        tgt = $urandom & `TLPRQ_TGT_MASK;
    endtask
    function automatic logic [31:0] d0(input logic [1:0] f,
        input logic [4:0] t, input logic [2:0] c, input logic [9:0] l);
        return {1'b0, f, t, 1'b0, c, 8'h00, 2'b00, l};
    endfunction
    task automatic send(input logic [31:0] ctrl, msg, input logic ok);
        int n;
        wb(1, `TLPRQ_OFS_STATUS, 32'h0000_0006);
        wb(1, `TLPRQ_OFS_ID, id);
        wb(1, `TLPRQ_OFS_ADDRLO, lo);
        wb(1, `TLPRQ_OFS_ADDRHI, hi);
        wb(1, `TLPRQ_OFS_TARGET, tgt);
        wb(1, `TLPRQ_OFS_MSG, msg);
        wb(1, `TLPRQ_OFS_DATA, dat);
        // Kind and flags settle before GO, because GO decodes the control
        // register as it stands at the edge where the GO write is taken.
        wb(1, `TLPRQ_OFS_CTRL, ctrl);
        PEER.gotQ.delete();
        PEER.markQ.delete();
        wb(1, `TLPRQ_OFS_CTRL, ctrl | 32'h0000_0100);
        n = 0;
        do begin
            wb(0, `TLPRQ_OFS_STATUS, 32'h0000_0000);
            n++;
        end while (r[2:1] === 2'b00 && n < 100);
        wb(0, `TLPRQ_OFS_STATUS, 32'h0000_0000);
        chk("status", ok ? 3'h4 : 3'h2, r[2:0]);
        chk("errcnt", expErr, r[15:8]);
        chk("words", exp.size(), PEER.gotQ.size());
        foreach (exp[i])
            if (i < PEER.gotQ.size()) begin
                chk("word", exp[i], PEER.gotQ[i]);
                chk("frame", {i == 0, i == exp.size() - 1}, PEER.markQ[i]);
            end
        exp.delete();
    endtask
    initial begin
        void'($urandom(32'h9e39));
        repeat (20) @(posedge core_clk);
        sys_rst <= 0;
        wb(0, `TLPRQ_OFS_STATUS, 32'h0000_0000);
        chk("status reset", 32'h0000_0000, r);
        wb(0, 8'h20, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, r);
        for (int k = 0; k < 4; k++) begin
            rnd();
            w = k == 1 || k == 2;
            cfg = k >= 2;
            t1 = k == 3;
            exp.push_back(d0({w, 1'b0}, cfg ? {4'h2, t1} : 5'h02, 3'h0,
                10'h001));
            exp.push_back({id[15:0], id[23:16], 4'h0, tgt[29:26]});
            exp.push_back(cfg ? {tgt[7:0], tgt[12:8], tgt[15:13], 4'h0,
                tgt[25:22], tgt[21:16], 2'b00} : lo);
            if (w) exp.push_back(dat);
            send({26'h0, t1, w, 1'b0, 2'b00, cfg},
                0, 1);
        end
        for (int k = 0; k < 2; k++) begin
            rnd();
            hi = k ? ($urandom | 32'h0000_0001) : 32'h0000_0000;
            exp.push_back(d0({1'b1, k[0]}, 5'h00, 3'h0, 10'h001));
            exp.push_back({id[15:0], id[23:16], 4'h0, tgt[29:26]});
            if (k) exp.push_back(hi);
            exp.push_back(lo);
            exp.push_back(dat);
            send(32'h0000_0004, 0, 1);
        end
        hi = $urandom;
        for (int j = 0; j < 6; j++) begin
            rnd();
            code = j == 5 ? 8'h01 : j == 4 ? 8'h02 : 8'h10;
            dm = j == 4;
            tc = $urandom;
            rt = j[2:0];
            exp.push_back(d0({dm, 1'b1}, {2'b10, rt}, tc, {9'h0, dm}));
            exp.push_back({id[15:0], id[23:16], code});
            exp.push_back(j == 1 ? hi : 32'h0000_0000);
            exp.push_back(j == 1 ? lo : 32'h0000_0000);
            if (dm) exp.push_back(dat);
            send(32'h0000_0002, {14'h0, tc, 3'h0, dm, rt, code},
                1);
        end
        for (int j = 0; j < 8; j++) begin
            rnd();
            exp.push_back(d0(2'b01, 5'h14, 3'h0, 10'h000));
            exp.push_back({id[15:0], id[23:16], 8'h20 + j[7:0]});
            exp.push_back(32'h0000_0000);
            exp.push_back(32'h0000_0000);
            send(32'h0000_000B, {14'h0, 3'h5, j[2:0], 12'h000},
                1);
        end
        foreach (refuse[j]) begin
            rnd();
            send(refuse[j][63:32], refuse[j][31:0],
                0);
        end
        rnd();
        injectBad <= 1;
        expErr = 1;
        exp.push_back(d0(2'b00, 5'h02, 3'h0, 10'h001));
        exp.push_back({id[15:0], id[23:16], 4'h0, tgt[29:26]});
        exp.push_back(lo);
        send(32'h0000_0000, 0, 1);
        injectBad <= 0;
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        end_of_test();
    end
endmodule

// *** tb/tlprq_host_ctrl_sva.sv ***
// Port checks for the request generator: Wishbone answers and packet words.
// Assumes one clock and a synchronous active-high reset.
module tlprq_host_ctrl_sva (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Wishbone
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [31:0] wbDatR_q,
    input wire wbAck_q,
    // Packet stream
    input wire txValid_q,
    input wire txSop_q,
    input wire txEop_q,
    input wire [31:0] txData_q,
    input wire txReady,
    input wire malformedPulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire sop = txValid_q && txSop_q;
    wire [4:0] typ = txData_q[28:24];
    wire fixOk = txData_q[22:20] == 3'h0 && txData_q[13:12] == 2'h0
        && txData_q[9:0] == 10'h001;

    a_ack_follows: assert property (wbCyc && wbStb && !wbAck_q |=> wbAck_q)
        else $error("ack missing after request");
    a_ack_single: assert property (wbAck_q |=> !wbAck_q)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wbAck_q) |-> $past(wbCyc && wbStb))
        else $error("ack without request");
    a_rdata_idle: assert property (!wbAck_q |-> wbDatR_q == 32'h0000_0000)
        else $error("read data outside ack");
    a_word_held: assert property (txValid_q && !txReady |=> txValid_q
        && $stable(txData_q) && $stable(txSop_q) && $stable(txEop_q))
        else $error("word changed before taken");
    a_word_gap: assert property (txValid_q && txReady |=> !txValid_q [*2])
        else $error("valid gap too short");
    a_io_fields: assert property (sop && typ == 5'h02
        |-> !txData_q[29] && fixOk)
        else $error("bad io header");
    a_cfg_fields: assert property (sop && typ[4:1] == 4'h2
        |-> !txData_q[29] && fixOk)
        else $error("bad config header");
    a_msg_fields: assert property (sop && typ[4:3] == 2'h2
        |-> txData_q[29] && txData_q[13:12] == 2'h0 && typ[2:1] != 2'h3)
        else $error("bad message header");

    cover property (txValid_q && txReady && txEop_q);
    cover property (txValid_q && !txReady);
    cover property (malformedPulse);
    cover property (wbAck_q && wbWe);
endmodule

bind tlprq_host_ctrl tlprq_host_ctrl_sva u_sva (.core_clk(core_clk),
    .sys_rst(sys_rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbDatR_q(wbDatR_q), .wbAck_q(wbAck_q), .txValid_q(txValid_q),
    .txSop_q(txSop_q), .txEop_q(txEop_q), .txData_q(txData_q),
    .txReady(txReady), .malformedPulse(malformedPulse));

// *** tb/tlprq_peer.sv ***
// Behavioural checking port: takes request words and flags bad packets.
// Assumes each word is held until ready and packets are framed by sop/eop.
module tlprq_peer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Request words
    input wire logic txValid_q,
    input wire logic txSop_q,
    input wire logic txEop_q,
    input wire logic [31:0] txData_q,
    output logic txReady,
    // Error report and test control
    output logic malformedPulse,
    input wire logic injectBad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] gotQ[$];
    logic [1:0] markQ[$];
    int s = 0;
    function automatic logic bad(input logic [31:0] h, d1);
        logic [4:0] t;
        t = h[28:24];
        if (t == 5'h02 || t[4:1] == 4'h2)
            return h[22:20] != 3'h0 || h[13:12] != 2'h0
                || h[9:0] != 10'h001 || d1[7:4] != 4'h0;
        if (t[4:3] == 2'h2 && d1[7:3] == 5'h04)
            return h[22:20] != 3'h0 || t[2:0] != 3'h4 || h[30];
        return 1'b0;
    endfunction
    // Messages of any route, reserved ones too, end here with no completion.
    always @(posedge core_clk) begin
        malformedPulse <= 1'b0;
        txReady <= ($urandom % 3) != 0;
        if (sys_rst) begin
            txReady <= 1'b0;
        end else if (txValid_q && txReady) begin
            if (txSop_q) s = gotQ.size();
            gotQ.push_back(txData_q);
            markQ.push_back({txSop_q, txEop_q});
            if (txEop_q)
                malformedPulse <= injectBad ||
                    bad(gotQ[s], gotQ[s+1]);
        end
    end
endmodule
